// [rtl/dicr_top.sv]
`include "dicr_regs.svh"

module dicr_top
   import dicr_pkg::*;
#(
   parameter int NUM_INPUTS = 5,
   parameter int NUM_OUTPUTS = 2,
   parameter int TICK_CYCLES = `DICR_TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [NUM_INPUTS-1:0] phys_in,
   input wire dicr_sens_t sensors,
   output logic [NUM_INPUTS-1:0] threshold_24v,
   output logic limit_neg,
   output logic limit_pos,
   output logic home_switch,
   output logic [NUM_OUTPUTS-1:0] output_level
);

   localparam int TW = $clog2(TICK_CYCLES);

   // Refuse sizes the logic cannot serve.
   generate
      if (NUM_INPUTS < 3 || NUM_INPUTS > 16) begin : g_bad_inputs
         $error("NUM_INPUTS must lie between 3 and 16.");
      end
      if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 16) begin : g_bad_outputs
         $error("NUM_OUTPUTS must lie between 1 and 16.");
      end
      if (TICK_CYCLES < 2) begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2.");
      end
   endgenerate

   // State of the register group.
   dicr_cfg_t cfg, next_cfg;
   logic [31:0] ocw, next_ocw;
   logic aw_full, next_aw_full;
   logic w_full, next_w_full;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready;
   logic next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [NUM_OUTPUTS-1:0] next_output_level;
   logic [NUM_INPUTS-1:0] next_threshold_24v;

   // State of the sampling group.
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic [NUM_INPUTS-1:0] raw, next_raw;
   logic [NUM_INPUTS-1:0] stable, next_stable;
   dicr_sens_t sens_q, next_sens_q;
   logic [31:0] in_word, next_in_word;
   logic next_limit_neg, next_limit_pos, next_home_switch;

   // Routing table, one source code per input word bit.
   logic [7:0] route_tab [32];
   logic [7:0] next_route_tab [32];

   // Combinational helpers.
   logic [NUM_INPUTS-1:0] proc_in;
   logic [31:0] normal_word;
   logic [31:0] routed_word;
   logic [7:0] init_tab [32];
   logic [15:0] phys16;

   // Merges a written word into a register under the byte strobes.
   function automatic logic [31:0] dicr_merge(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction : dicr_merge

   // Resolves one routing source code to a signal level.
   function automatic logic dicr_route_bit(input logic [7:0] code,
         input logic [15:0] phys, input dicr_sens_t s);
      logic base;
      logic ok;
      logic [3:0] idx;
      base = 1'b0;
      ok = 1'b1;
      idx = 4'(code[6:0] - 7'h01);
      if (code[6:0] == 7'h00) begin
         base = 1'b0;
      end else if (code[6:0] <= `DICR_SRC_PHYS_MAX) begin
         base = phys[idx]; // RQ17
         ok = (32'(idx) < NUM_INPUTS); // RQ22
      end else begin
         case (code[6:0])
            `DICR_SRC_HALL_U: base = s.hall_u;
            `DICR_SRC_HALL_V: base = s.hall_v;
            `DICR_SRC_HALL_W: base = s.hall_w;
            `DICR_SRC_ENC_A: base = s.enc_a;
            `DICR_SRC_ENC_B: base = s.enc_b;
            `DICR_SRC_ENC_IDX: base = s.enc_index;
            `DICR_SRC_USB: base = s.usb_power;
            default: ok = 1'b0; // RQ22
         endcase
      end
      return ok & (base ^ code[7]); // RQ18
   endfunction : dicr_route_bit

   // Inversion then forcing, then normal placement of each input.
   assign phys16 = 16'(stable);
   generate
      for (genvar n = 0; n < 32; n++) begin : g_bit
         if (n < NUM_INPUTS) begin : g_in
            assign proc_in[n] = cfg.fen[n] ? cfg.fval[n] // RQ9 RQ10 RQ21
                                : (stable[n] ^ cfg.inv[n]); // RQ8
         end
         if (n < `DICR_NUM_SPECIAL) begin : g_special
            assign normal_word[n] = proc_in[n] & cfg.sfe[n]; // RQ1 RQ6 RQ7
            assign init_tab[n] = cfg.sfe[n] ? init_tab[n+16]
                                 : `DICR_RST_ENTRY; // RQ15
         end else if (n < `DICR_LEVEL_BASE) begin : g_spare
            assign normal_word[n] = 1'b0;
            assign init_tab[n] = `DICR_RST_ENTRY;
         end else if (n - `DICR_LEVEL_BASE < NUM_INPUTS) begin : g_level
            assign normal_word[n] = proc_in[n-16]; // RQ2 RQ4
            assign init_tab[n] = cfg.fen[n-16]
                  ? {cfg.fval[n-16], 7'h00}
                  : {cfg.inv[n-16], 7'(n-15)}; // RQ15
         end else begin : g_none
            assign normal_word[n] = 1'b0;
            assign init_tab[n] = `DICR_RST_ENTRY;
         end
         assign routed_word[n] =
               dicr_route_bit(route_tab[n], phys16, sens_q); // RQ16
      end
   endgenerate

   // Next values of the sampling group.
   always_comb begin
      next_tick_cnt = tick_cnt + 1'b1;
      next_raw = raw;
      next_stable = stable;
      next_sens_q = sensors;
      if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_raw = phys_in; // RQ5 RQ11
         for (int i = 0; i < NUM_INPUTS; i++) begin
            if (phys_in[i] == raw[i]) begin
               next_stable[i] = phys_in[i]; // RQ5
            end
         end
      end
      next_in_word = cfg.route_en ? routed_word // RQ14
                     : normal_word;
      next_limit_neg = in_word[`DICR_BIT_NEG_LIMIT]; // RQ6
      next_limit_pos = in_word[`DICR_BIT_POS_LIMIT]; // RQ6
      next_home_switch = in_word[`DICR_BIT_HOME]; // RQ6
   end

   // Registers of the sampling group.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= '0;
         raw <= '0;
         stable <= '0;
         sens_q <= '0;
         in_word <= `DICR_RST_WORD;
         limit_neg <= 1'b0;
         limit_pos <= 1'b0;
         home_switch <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         raw <= next_raw;
         stable <= next_stable;
         sens_q <= next_sens_q;
         in_word <= next_in_word;
         limit_neg <= next_limit_neg;
         limit_pos <= next_limit_pos;
         home_switch <= next_home_switch;
      end
   end

   // Next values of the bus slave, the registers and the table.
   always_comb begin
      next_cfg = cfg;
      next_ocw = ocw;
      next_aw_full = aw_full;
      next_w_full = w_full;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      for (int i = 0; i < 32; i++) begin
         next_route_tab[i] = route_tab[i];
      end
      // Capture address and data in either order.
      if (awvalid && awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_full = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      // Perform the write once both halves are held.
      if (aw_full && w_full && !bvalid) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `DICR_RESP_OKAY;
         if (aw_addr[7]) begin
            if (w_strb[0]) begin
               next_route_tab[aw_addr[6:2]] = w_data[7:0];
            end
         end else begin
            case ({aw_addr[7:2], 2'b00})
               `DICR_OFS_SFE:
                  next_cfg.sfe = dicr_merge(cfg.sfe, w_data, w_strb);
               `DICR_OFS_INV:
                  next_cfg.inv = dicr_merge(cfg.inv, w_data, w_strb);
               `DICR_OFS_FEN:
                  next_cfg.fen = dicr_merge(cfg.fen, w_data, w_strb);
               `DICR_OFS_FVAL:
                  next_cfg.fval = dicr_merge(cfg.fval, w_data, w_strb);
               `DICR_OFS_THR:
                  next_cfg.thr = dicr_merge(cfg.thr, w_data, w_strb);
               `DICR_OFS_OCW:
                  next_ocw = dicr_merge(ocw, w_data, w_strb);
               `DICR_OFS_REN: begin
                  if (w_strb[0]) begin
                     next_cfg.route_en = w_data[0]; // RQ13
                     if (w_data[0] && !cfg.route_en) begin
                        for (int i = 0; i < 32; i++) begin
                           next_route_tab[i] = init_tab[i]; // RQ15
                        end
                     end
                  end
               end
               `DICR_OFS_RAW, `DICR_OFS_SUM: ;
               default: next_bresp = `DICR_RESP_DECERR;
            endcase
         end
      end
      // Answer a read one cycle after its address is taken.
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = `DICR_RESP_OKAY;
         next_rdata = '0;
         if (araddr[7]) begin
            next_rdata = {24'h000000, route_tab[araddr[6:2]]};
         end else begin
            case ({araddr[7:2], 2'b00})
               `DICR_OFS_SFE: next_rdata = cfg.sfe;
               `DICR_OFS_INV: next_rdata = cfg.inv;
               `DICR_OFS_FEN: next_rdata = cfg.fen;
               `DICR_OFS_FVAL: next_rdata = cfg.fval;
               `DICR_OFS_RAW: next_rdata = 32'(raw); // RQ11
               `DICR_OFS_THR: next_rdata = cfg.thr;
               `DICR_OFS_REN: next_rdata = {31'h00000000, cfg.route_en};
               `DICR_OFS_SUM: next_rdata = in_word;
               `DICR_OFS_OCW: next_rdata = ocw;
               default: next_rresp = `DICR_RESP_DECERR;
            endcase
         end
      end
      next_awready = !next_aw_full;
      next_wready = !next_w_full;
      next_arready = !next_rvalid;
      next_threshold_24v = next_cfg.thr[NUM_INPUTS-1:0]; // RQ12
      next_output_level =
            next_ocw[`DICR_LEVEL_BASE +: NUM_OUTPUTS]; // RQ3 RQ20
   end

   // Registers of the bus slave group.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= '0;
         ocw <= `DICR_RST_WORD;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         rvalid <= 1'b0;
         rresp <= 2'b00;
         rdata <= 32'h00000000;
         threshold_24v <= '0;
         output_level <= '0;
      end else begin
         cfg <= next_cfg;
         ocw <= next_ocw;
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         threshold_24v <= next_threshold_24v;
         output_level <= next_output_level;
      end
   end

   // Routing table storage.
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 32; i++) begin
         if (!aresetn) begin
            route_tab[i] <= `DICR_RST_ENTRY;
         end else begin
            route_tab[i] <= next_route_tab[i];
         end
      end
   end

endmodule : dicr_top

// [rtl/dicr_regs.svh]
// Operation
// RQ1: Special-function bits occupy input word bits 0-15.
// RQ2: Level of input n sits at bit 15+n.
// RQ3: Output two level driven from output bit 17.
// RQ4: Bit 16 always shows input one status.
// RQ5: Sample every millisecond, drop shorter pulses.
// RQ6: Bits 0,1,2: negative limit, positive limit, home.
// RQ7: Special-enable gates special bits, not level bits.
// RQ8: Invert bit selects normally closed logic.
// RQ9: Force-enable replaces the sampled input value.
// RQ10: Forced value comes from matching force-value bit.
// RQ11: Raw word shows unmodified sampled levels.
// RQ12: Threshold select: 0 is 5 V, 1 is 24 V.
// RQ13: Writing 1 to routing enable starts routing.
// RQ14: Routing ignores enable, invert and force settings.
// RQ15: Routing start loads table mimicking prior behaviour.
// RQ16: Input word bit n uses table entry n.
// RQ17: Decode source codes for inputs, sensors, USB.
// RQ18: Code bit 7 inverts the selected source.
// RQ19: Software should not toggle routing mode repeatedly.
// RQ20: Output routing codes are out of scope here.
// RQ21: Invert first, force second, then derive bits.
// RQ22: Missing inputs or sensors read as zero.
`ifndef DICR_REGS_SVH
`define DICR_REGS_SVH

// Register byte offsets on the register bus.
`define DICR_OFS_SFE 8'h00
`define DICR_OFS_INV 8'h04
`define DICR_OFS_FEN 8'h08
`define DICR_OFS_FVAL 8'h0C
`define DICR_OFS_RAW 8'h10
`define DICR_OFS_THR 8'h14
`define DICR_OFS_REN 8'h18
`define DICR_OFS_SUM 8'h1C
`define DICR_OFS_OCW 8'h20
`define DICR_OFS_TABLE 8'h80

// Field positions inside the input word.
`define DICR_BIT_NEG_LIMIT 0
`define DICR_BIT_POS_LIMIT 1
`define DICR_BIT_HOME 2
`define DICR_LEVEL_BASE 16
`define DICR_NUM_SPECIAL 3

// Routing source codes.
`define DICR_SRC_PHYS_MAX 7'h10
`define DICR_SRC_HALL_U 7'h41
`define DICR_SRC_HALL_V 7'h42
`define DICR_SRC_HALL_W 7'h43
`define DICR_SRC_ENC_A 7'h44
`define DICR_SRC_ENC_B 7'h45
`define DICR_SRC_ENC_IDX 7'h46
`define DICR_SRC_USB 7'h47

// Reset values.
`define DICR_RST_WORD 32'h00000000
`define DICR_RST_ENTRY 8'h00

// Sampling period and clock rate.
`define DICR_TICK_US 1000
`define DICR_CLK_MHZ 100
`define DICR_TICK_CYCLES (`DICR_TICK_US * `DICR_CLK_MHZ)

// AXI responses.
`define DICR_RESP_OKAY 2'b00
`define DICR_RESP_DECERR 2'b11

`endif

// [rtl/dicr_pkg.sv]
package dicr_pkg;

   // Software configuration of the input path.
   typedef struct packed {
      logic [31:0] sfe;
      logic [31:0] inv;
      logic [31:0] fen;
      logic [31:0] fval;
      logic [31:0] thr;
      logic route_en;
   } dicr_cfg_t;

   // Fast sensor signals offered to the routing table.
   typedef struct packed {
      logic usb_power;
      logic enc_index;
      logic enc_b;
      logic enc_a;
      logic hall_w;
      logic hall_v;
      logic hall_u;
   } dicr_sens_t;

endpackage : dicr_pkg

// [tb/dicr_checker_properties.sv]
module dicr_checker
   import dicr_pkg::*;
#(
   parameter int NUM_INPUTS = 5,
   parameter int NUM_OUTPUTS = 2,
   parameter int TICK_CYCLES = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [NUM_INPUTS-1:0] threshold_24v,
   input wire logic limit_neg,
   input wire logic limit_pos,
   input wire logic home_switch,
   input wire logic [NUM_OUTPUTS-1:0] output_level
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] wa_q, ra_q, next_wa, next_ra;
   logic [31:0] wd_q, next_wd;
   logic [8:0][31:0] shadow, next_sh;

   // Shadow of the written registers, updated when a write completes.
   always_comb begin
      next_wa = (awvalid && awready) ? awaddr : wa_q;
      next_ra = (arvalid && arready) ? araddr : ra_q;
      next_wd = (wvalid && wready) ? wdata : wd_q;
      next_sh = shadow;
      if (bvalid && bready && wa_q < 8'h24) next_sh[wa_q[5:2]] = wd_q;
   end

   // Registers the shadow; reset clears it like the block's registers.
   always_ff @(posedge aclk) begin
      wa_q <= aresetn ? next_wa : 8'h00;
      ra_q <= aresetn ? next_ra : 8'h00;
      wd_q <= aresetn ? next_wd : 32'h00000000;
      shadow <= aresetn ? next_sh : '0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sum;
      $rose(rvalid) && ra_q == 8'h1C && !shadow[6][0];
   endsequence

   a_unused_zero: assert property (s_sum |-> rdata[15:3] == 13'h0000
      && rdata[31:21] == 11'h000) else $error("unused summary bits set");
   a_special_gate: assert property (s_sum |-> rdata[2:0] ==
      (rdata[18:16] & shadow[0][2:0])) else $error("special bit wrong");
   a_force_value: assert property (s_sum |->
      ((rdata[20:16] ^ shadow[3][4:0]) & shadow[2][4:0]) == 5'h00)
      else $error("forced level wrong");
   a_limit_pins: assert property ($rose(rvalid) && ra_q == 8'h1C |=>
      {home_switch, limit_pos, limit_neg} == $past(rdata[2:0]))
      else $error("switch outputs differ from summary");
   a_raw_width: assert property ($rose(rvalid) && ra_q == 8'h10 |->
      rdata[31:NUM_INPUTS] == '0) else $error("raw word upper bits set");
   a_thr_follow: assert property (bvalid && bready && wa_q == 8'h14
      |-> ##[0:2] threshold_24v == wd_q[NUM_INPUTS-1:0])
      else $error("threshold select not applied");
   a_out_two: assert property (bvalid && bready && wa_q == 8'h20
      |-> ##[0:2] output_level == wd_q[16+:NUM_OUTPUTS])
      else $error("output level not applied");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |=> ##1 bvalid) else $error("write answer late");

   c_summary: cover property (s_sum);
   c_routed: cover property ($rose(rvalid) && ra_q == 8'h1C && shadow[6][0]);
   c_output: cover property (bvalid && bready && wa_q == 8'h20);
endmodule : dicr_checker

bind dicr_top dicr_checker #(.NUM_INPUTS(NUM_INPUTS),
   .NUM_OUTPUTS(NUM_OUTPUTS), .TICK_CYCLES(TICK_CYCLES)) u_checker (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
   .threshold_24v(threshold_24v), .limit_neg(limit_neg),
   .limit_pos(limit_pos), .home_switch(home_switch),
   .output_level(output_level));

// [tb/dicr_field.sv]
module dicr_field
   import dicr_pkg::*;
(
   input wire logic aclk,
   input wire logic [4:0] target,
   input wire dicr_sens_t sens_target,
   input wire logic bounce,
   output logic [4:0] phys_in,
   output dicr_sens_t sensors
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] settled;
   logic [2:0] bcnt;

   initial begin
      phys_in = 5'h00;
      sensors = '0;
      settled = 5'h00;
      bcnt = 3'h0;
   end

   // Contacts may chatter for eight cycles, well inside one sampling tick.
   always @(posedge aclk) begin
      sensors <= sens_target;
      if (target != settled) begin
         bcnt <= bcnt + 3'h1;
         phys_in <= (bounce && bcnt[0]) ? settled : target;
         if (!bounce || bcnt == 3'h7) begin
            settled <= target;
            phys_in <= target;
            bcnt <= 3'h0;
         end
      end
   end
endmodule : dicr_field

// [tb/digital_input_conditioning_router_bench.sv]
`include "dicr_regs.svh"

module digital_input_conditioning_router_bench
   import dicr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 20;
   logic aclk = 1'b0, aresetn = 1'b0, bounce = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, d;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic limit_neg, limit_pos, home_switch;
   logic [1:0] bresp, rresp, r, output_level;
   logic [4:0] phys_in, threshold_24v, target = 5'h00;
   dicr_sens_t sensors, sens_target = '0;
   int n_errors = 0, comparisons = 0, seed = 68;
   int cfg [5], tbl [32], lvl, sens, route, c;
   int codes [22] = '{0, 128, 1, 5, 6, 133, 134, 144, 65, 66, 67, 68, 69,
      70, 71, 193, 194, 195, 196, 197, 198, 199};

   initial forever #5 aclk = ~aclk;

   dicr_top #(.TICK_CYCLES(TICK)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .phys_in(phys_in), .sensors(sensors), .threshold_24v(threshold_24v),
      .limit_neg(limit_neg), .limit_pos(limit_pos),
      .home_switch(home_switch), .output_level(output_level));

   dicr_field i_field (.aclk(aclk), .target(target),
      .sens_target(sens_target), .bounce(bounce), .phys_in(phys_in),
      .sensors(sensors));

   task automatic chk_word(input string what, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk_word

   task automatic chk_resp(input string what, input logic [1:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask : chk_resp

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // Source decoder: unknown or absent sources read 0, inverted ones too.
   function automatic int src(int code);
      int b = code & 127;
      int v = 0;
      if (b >= 1 && b <= 5) v = (lvl >> (b - 1)) & 1;
      else if (b >= 65 && b <= 71) v = (sens >> (b - 65)) & 1;
      else if (b != 0) return 0;
      return v ^ ((code >> 7) & 1);
   endfunction : src

   // Expected summary word: invert, then force, then special gating.
   function automatic int model_sum();
      int s = 0;
      int p;
      for (int n = 0; n < 32; n++) begin
         if (route != 0) s |= src(tbl[n]) << n;
         else if (n < 5) begin
            p = cfg[2][n] ? cfg[3][n] : lvl[n] ^ cfg[1][n];
            s |= p << (16 + n);
            if (n < 3 && cfg[0][n]) s |= p << n;
         end
      end
      return s;
   endfunction : model_sum

   task automatic check_sum();
      rd(8'h1C);
      chk_word("summary", model_sum(), d);
   endtask : check_sum

   task automatic final_report();
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Watchdog far beyond the roughly 1200 cycles the sequence needs.
   initial begin
      #200000;
      n_errors++;
      final_report();
   end

   // Main sequence: reset, normal path, filter, outputs, bus, routing.
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a <= 32; a += 4) begin
         rd(8'(a));
         chk_word("reset value", 32'h00000000, d);
      end
      for (int i = 0; i < 6; i++) begin
         lvl = $random(seed) & 31;
         target <= lvl[4:0];
         bounce <= i[0];
         for (int k = 0; k < 5; k++) begin
            cfg[k] = $random(seed) & 31;
            wr(8'(k < 4 ? k * 4 : 20), cfg[k]);
            rd(8'(k < 4 ? k * 4 : 20));
            chk_word("config readback", cfg[k], d);
         end
         repeat (4 * TICK + 10) @(posedge aclk);
         rd(8'h10);
         chk_word("raw levels", lvl, d);
         check_sum();
         chk_word("threshold", cfg[4], 32'(threshold_24v));
         chk_word("switches", model_sum() & 7,
            {home_switch, limit_pos, limit_neg});
      end
      // A pulse shorter than one tick must never show in the summary.
      bounce <= 1'b0;
      target <= lvl[4:0] ^ 5'h1F;
      repeat (6) check_sum();
      target <= lvl[4:0];
      repeat (8) check_sum();
      for (int k = 1; k < 4; k++) begin
         wr(8'h20, k << 16);
         repeat (3) @(posedge aclk);
         chk_word("output level", k, 32'(output_level));
      end
      rd(8'h40);
      chk_resp("unmapped read", `DICR_RESP_DECERR, r);
      chk_word("unmapped data", 32'h00000000, d);
      wr(8'h40, 32'hFFFFFFFF);
      chk_resp("unmapped write", `DICR_RESP_DECERR, r);
      wr(8'h1C, 32'hFFFFFFFF);
      chk_resp("read-only write", `DICR_RESP_OKAY, r);
      check_sum();
      sens = $random(seed) & 127;
      sens_target <= sens[6:0];
      wr(8'h18, 32'h00000001);
      route = 1;
      for (int n = 0; n < 32; n++) begin
         c = n - 16;
         tbl[n] = 0;
         if (n >= 16 && n < 21) tbl[n] = cfg[2][c] ? cfg[3][c] << 7 :
            (cfg[1][c] << 7) | (c + 1);
         if (n < 3 && cfg[0][n]) tbl[n] = cfg[2][n] ? cfg[3][n] << 7 :
            (cfg[1][n] << 7) | (n + 1);
         rd(8'(128 + 4 * n));
         chk_word("table start", tbl[n], d);
      end
      check_sum();
      cfg[1] ^= 31;
      wr(8'h04, cfg[1]);
      check_sum();
      for (int i = 0; i < 22; i++) begin
         if (i == 15) sens = $random(seed) & 127;
         sens_target <= sens[6:0];
         tbl[(i * 7) % 32] = codes[i];
         wr(8'(128 + 4 * ((i * 7) % 32)), codes[i]);
         check_sum();
      end
      wr(8'h18, 32'h00000000);
      route = 0;
      check_sum();
      final_report();
   end
endmodule : digital_input_conditioning_router_bench
